// >>> logic/pmc_top.sv
// Power mode, phase clock and vector table control
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pmc_map.svh"
// Notes on behaviour
// [RL1] Deep idle: no execution, state kept, bus idle
// [RL2] Idle holds phase one high, three low
// [RL3] Slow clock mode runs core at input/16
// [RL4] Each external interrupt edge or level triggered
// [RL5] Vector base relocatable on 256-word boundary
// [RL6] Reset vector always fetched from zero
// [RL7] Wake restarts phase clocks cleanly before service
module pmc_top #(
    parameter int SLOW_DIV = `PMC_SLOW_DIV
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire pmc_pkg::pmc_reg_addr_t addr_i,
    input wire pmc_pkg::pmc_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output pmc_pkg::pmc_word_t rdata_o,
    input wire pmc_pkg::pmc_int_t ext_int_i,
    input wire logic vec_req_i,
    input wire logic vec_reset_i,
    input wire pmc_pkg::pmc_vnum_t vec_num_i,
    output pmc_pkg::pmc_vaddr_t vec_addr_o,
    output logic vec_valid_o,
    output logic ph1_clk_o,
    output logic ph3_clk_o,
    output logic core_ce_o,
    output logic bus_idle_o,
    output pmc_pkg::pmc_int_t cpu_int_o,
    output logic irq_o
);
    import pmc_pkg::*;
    localparam int DW = $clog2(SLOW_DIV);
    localparam int N = `PMC_NUM_INT;
    localparam int SW = `PMC_STAT_W;
    localparam int VW = `PMC_ADDR_W - `PMC_VEC_LSB;

    pmc_irq_if irq ();

    pmc_irq_sync u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .ext_int_i(ext_int_i),
        .irq(irq.det)
    );

    // ****************************************
    // Register file and interrupt status
    // ****************************************
    logic slow_ff, nxt_slow, idle_req_ff, nxt_idle_req;
    logic [N-1:0] trig_ff, nxt_trig, cpu_int_ff, nxt_cpu_int;
    logic [VW-1:0] vbase_ff, nxt_vbase;
    logic [SW-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
    logic irq_ff, nxt_irq;
    pmc_word_t rdata_ff, nxt_rdata;
    pmc_state_t state_ff, nxt_state;
    logic ph_ff, nxt_ph;
    assign irq.edge_mode = trig_ff;

    always_comb begin
        nxt_slow = slow_ff;
        nxt_idle_req = idle_req_ff;
        nxt_trig = trig_ff;
        nxt_vbase = vbase_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        nxt_rdata = '0;
        if (wr_i) begin
            case (addr_i)
                `PMC_A_CTRL: begin
                    // [RL3] Slow mode select
                    nxt_slow = wdata_i[`PMC_B_SLOW];
                    if (wdata_i[`PMC_B_IDLE]) begin
                        nxt_idle_req = 1'b1;
                    end
                end
                `PMC_A_TRIG: nxt_trig = wdata_i[N-1:0];
                // [RL5] Low bits of base forced to zero
                `PMC_A_VBASE: nxt_vbase = wdata_i[`PMC_ADDR_W-1:`PMC_VEC_LSB];
                `PMC_A_STAT: nxt_stat = stat_ff & ~wdata_i[SW-1:0];
                `PMC_A_MASK: nxt_mask = wdata_i[SW-1:0];
                default: ;
            endcase
        end
        if (state_ff == PMC_IDLE) begin
            nxt_idle_req = 1'b0;
        end
        // Set after clear so an event in the clearing cycle survives
        nxt_stat = nxt_stat | {state_ff == PMC_WAKE, irq.hit};
        if (rd_i) begin
            case (addr_i)
                `PMC_A_CTRL: nxt_rdata = 32'({slow_ff, idle_req_ff});
                `PMC_A_TRIG: nxt_rdata = 32'(trig_ff);
                `PMC_A_VBASE: nxt_rdata = 32'({vbase_ff, 8'h00});
                `PMC_A_STAT: nxt_rdata = 32'(stat_ff);
                `PMC_A_MASK: nxt_rdata = 32'(mask_ff);
                `PMC_A_STATE: nxt_rdata = 32'({ph_ff, state_ff});
                default: nxt_rdata = '0;
            endcase
        end
        nxt_irq = |(nxt_stat & nxt_mask);
        // [RL7] Service only once clocks run again
        nxt_cpu_int = (state_ff == PMC_RUN && nxt_state == PMC_RUN) ?
            (stat_ff[N-1:0] & mask_ff[N-1:0]) : '0;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            slow_ff <= 1'b0;
            idle_req_ff <= 1'b0;
            trig_ff <= '0;
            vbase_ff <= '0;
            stat_ff <= '0;
            mask_ff <= '0;
            rdata_ff <= '0;
            irq_ff <= 1'b0;
            cpu_int_ff <= '0;
        end else if (ce_i) begin
            slow_ff <= nxt_slow;
            idle_req_ff <= nxt_idle_req;
            trig_ff <= nxt_trig;
            vbase_ff <= nxt_vbase;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            cpu_int_ff <= nxt_cpu_int;
        end
    end

    // ****************************************
    // Power modes, phase clocks and vectors
    // ****************************************
    logic [DW-1:0] div_ff, nxt_div;
    logic ph1_ff, nxt_ph1, ph3_ff, nxt_ph3, ce_ff, nxt_ce, bidle_ff, nxt_bidle;
    logic vv_ff, nxt_vv, tick;
    pmc_vaddr_t va_ff, nxt_va;

    always_comb begin
        nxt_state = state_ff;
        nxt_div = (div_ff == DW'(SLOW_DIV - 1)) ? '0 : div_ff + 1'b1;
        nxt_ph = ph_ff;
        nxt_ce = 1'b0;
        nxt_vv = 1'b0;
        nxt_va = va_ff;
        // [RL3] Divided tick in slow mode
        tick = !slow_ff || (div_ff == DW'(SLOW_DIV - 1));
        case (state_ff)
            PMC_RUN: begin
                // Enter only with phase one high, so the freeze cuts no pulse short
                if (idle_req_ff && !ph_ff) begin
                    nxt_state = PMC_IDLE;
                end else if (tick) begin
                    nxt_ce = 1'b1;
                    nxt_ph = ~ph_ff;
                end
                if (vec_req_i) begin
                    nxt_vv = 1'b1;
                    // [RL6] Fixed reset vector
                    if (vec_reset_i) begin
                        nxt_va = `PMC_RESET_VEC;
                    end else begin
                        // [RL5] Relocated table entry
                        nxt_va = {vbase_ff, vec_num_i};
                    end
                end
            end
            PMC_IDLE: begin
                // [RL2] Any asserted line ends idle
                nxt_div = '0;
                if (|irq.lvl) begin
                    nxt_state = PMC_WAKE;
                end
            end
            PMC_WAKE: begin
                // [RL7] Restart from a clean phase
                nxt_div = '0;
                nxt_state = PMC_RUN;
            end
            default: nxt_state = PMC_RUN;
        endcase
        nxt_ph1 = ~nxt_ph;
        nxt_ph3 = nxt_ph;
        // [RL1] Bus pins idle outside run
        nxt_bidle = (nxt_state != PMC_RUN);
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= PMC_RUN;
            div_ff <= '0;
            ph_ff <= 1'b0;
            ph1_ff <= 1'b1;
            ph3_ff <= 1'b0;
            ce_ff <= 1'b0;
            bidle_ff <= 1'b0;
            vv_ff <= 1'b0;
            va_ff <= '0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            div_ff <= nxt_div;
            ph_ff <= nxt_ph;
            ph1_ff <= nxt_ph1;
            ph3_ff <= nxt_ph3;
            ce_ff <= nxt_ce;
            bidle_ff <= nxt_bidle;
            vv_ff <= nxt_vv;
            va_ff <= nxt_va;
        end
    end

    assign rdata_o = rdata_ff;
    assign vec_addr_o = va_ff;
    assign vec_valid_o = vv_ff;
    assign ph1_clk_o = ph1_ff;
    assign ph3_clk_o = ph3_ff;
    assign core_ce_o = ce_ff;
    assign bus_idle_o = bidle_ff;
    assign cpu_int_o = cpu_int_ff;
    assign irq_o = irq_ff;
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // Gap between core enables; a pulse launched before slow mode took hold is not counted
    logic [7:0] gap_ff;
    logic clean_ff, slow_d_ff;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_ff <= '0;
            clean_ff <= 1'b0;
            slow_d_ff <= 1'b0;
        end else if (ce_i) begin
            gap_ff <= ce_ff ? 8'h00 : gap_ff + 8'h01;
            slow_d_ff <= slow_ff;
            if (!slow_ff || state_ff != PMC_RUN) begin
                clean_ff <= 1'b0;
            end else if (ce_ff && slow_d_ff) begin
                clean_ff <= 1'b1;
            end
        end
    end

    property p_idle_quiet;
        state_ff == PMC_IDLE |-> !core_ce_o && bus_idle_o && cpu_int_o == '0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("activity in deep idle"); // [RL1]

    property p_idle_phase;
        state_ff == PMC_IDLE |-> ph1_clk_o && !ph3_clk_o;
    endproperty
    a_idle_phase: assert property (p_idle_phase) else $error("phase clocks not parked"); // [RL2]

    property p_wake;
        state_ff == PMC_IDLE && ce_i && |irq.lvl |=> state_ff == PMC_WAKE;
    endproperty
    a_wake: assert property (p_wake) else $error("interrupt did not end idle"); // [RL2]

    property p_slow_gap;
        ce_i && core_ce_o && clean_ff && slow_ff |-> gap_ff == 8'(SLOW_DIV - 1);
    endproperty
    a_slow_gap: assert property (p_slow_gap) else $error("slow clock rate wrong"); // [RL3]

    property p_edge;
        trig_ff[0] && irq.hit[0] && $past(ce_i) |-> !$past(irq.lvl[0]);
    endproperty
    a_edge: assert property (p_edge) else $error("edge hit without rise"); // [RL4]

    property p_level;
        ce_i && !trig_ff[0] && irq.lvl[0] |=> stat_ff[0];
    endproperty
    a_level: assert property (p_level) else $error("level not latched"); // [RL4]

    property p_vec_reloc;
        ce_i && state_ff == PMC_RUN && vec_req_i && !vec_reset_i
            |=> vec_valid_o && vec_addr_o == {$past(vbase_ff), $past(vec_num_i)};
    endproperty
    a_vec_reloc: assert property (p_vec_reloc) else $error("relocated vector wrong"); // [RL5]

    property p_vec_reset;
        ce_i && state_ff == PMC_RUN && vec_req_i && vec_reset_i
            |=> vec_valid_o && vec_addr_o == `PMC_RESET_VEC;
    endproperty
    a_vec_reset: assert property (p_vec_reset) else $error("reset vector moved"); // [RL6]

    property p_wake_clean;
        ce_i && state_ff == PMC_WAKE |=> state_ff == PMC_RUN && ph1_clk_o && !ph3_clk_o;
    endproperty
    a_wake_clean: assert property (p_wake_clean) else $error("wake restart glitch"); // [RL7]

    property p_int_gated;
        cpu_int_o != '0 |-> $past(state_ff) == PMC_RUN;
    endproperty
    a_int_gated: assert property (p_int_gated) else $error("interrupt served while parked"); // [RL7]
endmodule

// >>> logic/pmc_map.svh
// Register offsets, field positions and timing counts of the power and vector control
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_A_CTRL 8'h00
`define PMC_A_TRIG 8'h04
`define PMC_A_VBASE 8'h08
`define PMC_A_STAT 8'h0c
`define PMC_A_MASK 8'h10
`define PMC_A_STATE 8'h14
`define PMC_B_IDLE 0
`define PMC_B_SLOW 1
`define PMC_B_WAKE 4
`define PMC_NUM_INT 4
`define PMC_STAT_W 5
`define PMC_SLOW_DIV 16
`define PMC_VEC_LSB 8
`define PMC_ADDR_W 24
`define PMC_RESET_VEC 24'h000000
`endif

// >>> logic/pmc_pkg.sv
// Types shared by the power and vector control
package pmc_pkg;
    typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_WAKE} pmc_state_t;
    typedef logic [7:0] pmc_reg_addr_t;
    typedef logic [31:0] pmc_word_t;
    typedef logic [23:0] pmc_vaddr_t;
    typedef logic [3:0] pmc_int_t;
    typedef logic [7:0] pmc_vnum_t;
endpackage

// >>> logic/pmc_irq_if.sv
// Interrupt line detector to controller signals
`timescale 1ns/1ps
`include "pmc_map.svh"
interface pmc_irq_if;
    logic [`PMC_NUM_INT-1:0] edge_mode;
    logic [`PMC_NUM_INT-1:0] lvl;
    wire logic [`PMC_NUM_INT-1:0] hit;
    modport det (input edge_mode, output lvl, output hit);
    modport ctl (output edge_mode, input lvl, input hit);
endinterface

// >>> logic/pmc_irq_sync.sv
// External interrupt synchroniser and edge or level detector
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_irq_sync (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [`PMC_NUM_INT-1:0] ext_int_i,
    pmc_irq_if.det irq
);
    localparam int N = `PMC_NUM_INT;
    logic [N-1:0] s1_ff, s2_ff, s3_ff;
    logic [N-1:0] nxt_s1, nxt_s2, nxt_s3;

    // ****************************************
    // Synchroniser
    // ****************************************
    always_comb begin
        nxt_s1 = ext_int_i;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (ce_i) begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end

    // ****************************************
    // Detection
    // ****************************************
    assign irq.lvl = s2_ff;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_det
            // [RL4] Edge or level
            assign irq.hit[g] = irq.edge_mode[g] ? (s2_ff[g] & ~s3_ff[g]) : s2_ff[g];
        end
    endgenerate
endmodule

// >>> testbench/power_mode_and_vector_control_tb.sv
// Self-checking bench for the power mode and vector control block
`timescale 1ns/1ps
`include "pmc_map.svh"
module power_mode_and_vector_control_tb;
    import pmc_pkg::*;
    // Short slow divider keeps the run brief; expectations derive from it
    localparam int DIV = 4;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    pmc_reg_addr_t addr_i = 8'h00;
    pmc_word_t wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    pmc_word_t rdata_o;
    pmc_int_t ext_int_i = 4'h0;
    logic vec_req_i = 1'b0;
    logic vec_reset_i = 1'b0;
    pmc_vnum_t vec_num_i = 8'h00;
    pmc_vaddr_t vec_addr_o;
    logic vec_valid_o, ph1_clk_o, ph3_clk_o, core_ce_o, bus_idle_o, irq_o;
    pmc_int_t cpu_int_o;
    int miscompares = 0;
    int num_checks = 0;
    pmc_word_t v;
    int n;

    pmc_top #(.SLOW_DIV(DIV)) dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ext_int_i(ext_int_i), .vec_req_i(vec_req_i), .vec_reset_i(vec_reset_i),
        .vec_num_i(vec_num_i), .vec_addr_o(vec_addr_o), .vec_valid_o(vec_valid_o),
        .ph1_clk_o(ph1_clk_o), .ph3_clk_o(ph3_clk_o), .core_ce_o(core_ce_o),
        .bus_idle_o(bus_idle_o), .cpu_int_o(cpu_int_o), .irq_o(irq_o));

    always #25 mclk_i = ~mclk_i;

    // ****************************************
    // Helpers
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task wr(input pmc_reg_addr_t a, input pmc_word_t d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task rchk(input pmc_reg_addr_t a, input pmc_word_t exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    task vec(input logic rst, input pmc_vnum_t num, input logic ev, input pmc_vaddr_t ea);
        @(posedge mclk_i);
        vec_req_i <= 1'b1;
        vec_reset_i <= rst;
        vec_num_i <= num;
        @(posedge mclk_i);
        vec_req_i <= 1'b0;
        #1;
        chk(32'(vec_valid_o), 32'(ev));
        chk(32'(vec_addr_o), 32'(ea));
    endtask
    task pulse_count(input int k);
        n = 0;
        repeat (k) begin
            cyc(1);
            if (core_ce_o === 1'b1) n++;
        end
    endtask
    task tally_and_finish;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Registers other than the state register read zero after reset
    task t_reset;
        for (int a = 0; a <= 16; a += 4) rchk(8'(a), 32'h0);
        rchk(8'h20, 32'h0);
    endtask
    task t_vector;
        wr(`PMC_A_VBASE, 32'h0012ab);
        rchk(`PMC_A_VBASE, 32'h001200);
        cyc(1);
        chk(rdata_o, 32'h0);
        vec(1'b0, 8'h05, 1'b1, 24'h001205);
        vec(1'b1, 8'h05, 1'b1, `PMC_RESET_VEC);
        vec(1'b0, 8'hff, 1'b1, 24'h0012ff);
    endtask
    task t_slow;
        wr(`PMC_A_CTRL, 32'h2);
        cyc(2);
        pulse_count(8 * DIV);
        chk(32'(n), 32'h8);
        wr(`PMC_A_CTRL, 32'h0);
        cyc(2);
        pulse_count(8);
        chk(32'(n), 32'h8);
    endtask
    task t_irq;
        wr(`PMC_A_MASK, 32'h1f);
        wr(`PMC_A_TRIG, 32'h0);
        @(posedge mclk_i) ext_int_i <= 4'h2;
        cyc(4);
        rchk(`PMC_A_STAT, 32'h2);
        chk(32'({irq_o, cpu_int_o}), 32'h12);
        wr(`PMC_A_STAT, 32'h2);
        rchk(`PMC_A_STAT, 32'h2);
        @(posedge mclk_i) ext_int_i <= 4'h0;
        cyc(4);
        wr(`PMC_A_STAT, 32'h2);
        rchk(`PMC_A_STAT, 32'h0);
        chk(32'(irq_o), 32'h0);
        wr(`PMC_A_TRIG, 32'h1);
        wr(`PMC_A_MASK, 32'h0);
        @(posedge mclk_i) ext_int_i <= 4'h1;
        cyc(4);
        rchk(`PMC_A_STAT, 32'h1);
        chk(32'({irq_o, cpu_int_o}), 32'h0);
        wr(`PMC_A_STAT, 32'h1);
        cyc(4);
        rchk(`PMC_A_STAT, 32'h0);
        @(posedge mclk_i) ext_int_i <= 4'h0;
        wr(`PMC_A_MASK, 32'h1f);
    endtask
    // Deep idle entry, hold and wake
    task t_idle;
        wr(`PMC_A_CTRL, 32'h1);
        n = 0;
        while (bus_idle_o !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(32'(bus_idle_o), 32'h1);
        pulse_count(8);
        chk(32'({n[3:0], ph1_clk_o, ph3_clk_o}), 32'h2);
        vec(1'b0, 8'h03, 1'b0, 24'h0012ff);
        rchk(`PMC_A_STATE, 32'h1);
        @(posedge mclk_i) ext_int_i <= 4'h4;
        n = 0;
        while (bus_idle_o !== 1'b0 && n < 10) begin
            cyc(1);
            n++;
            if (bus_idle_o === 1'b1) chk(32'({core_ce_o, ph1_clk_o, ph3_clk_o}), 32'h2);
        end
        chk(32'({core_ce_o, ph1_clk_o, ph3_clk_o}), 32'h2);
        cyc(1);
        chk(32'({core_ce_o, ph1_clk_o, ph3_clk_o}), 32'h5);
        rchk(`PMC_A_STAT, 32'h14);
        @(posedge mclk_i) ext_int_i <= 4'h0;
    endtask
    // Clock enable low keeps every state bit
    task t_freeze;
        @(posedge mclk_i) ce_i <= 1'b0;
        cyc(1);
        v = 32'({core_ce_o, ph1_clk_o, ph3_clk_o});
        wr(`PMC_A_MASK, 32'h0);
        cyc(3);
        chk(32'({core_ce_o, ph1_clk_o, ph3_clk_o}), v);
        chk(32'(core_ce_o), 32'h1);
        @(posedge mclk_i) ce_i <= 1'b1;
        rchk(`PMC_A_MASK, 32'h1f);
    endtask

    initial begin
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_vector();
        t_slow();
        t_irq();
        t_idle();
        t_freeze();
        tally_and_finish();
    end

    initial begin
        #(50 * 4000);
        miscompares++;
        tally_and_finish();
    end
endmodule
